//--- hdl/cpu_regfile_address_gen.v
// working register file with data and program address generation
// assumes a decoder outside drives one operation per cycle; i/o and sram are outside
`timescale 1ns/1ps
`include "regfile_consts.vh"

module cpu_regfile_address_gen (
   // clock and reset
   input  wire        sys_clk,
   input  wire        resetn,
   // register-to-register operation
   input  wire        alu_we,
   input  wire [4:0]  destination_operand_reg,
   input  wire [4:0]  source_operand_reg,
   input  wire [7:0]  alu_result,
   // immediate operation
   input  wire        imm_we,
   input  wire [3:0]  imm_reg,
   input  wire [7:0]  imm_result,
   // data access request
   input  wire [2:0]  addr_mode,
   input  wire [1:0]  ptr_sel,
   input  wire [5:0]  disp_field,
   input  wire [15:0] direct_word,
   input  wire [5:0]  io_field,
   input  wire        mem_write,
   input  wire [7:0]  mem_rdata,
   input  wire [4:0]  xfer_reg,
   // program counter control
   input  wire [1:0]  pc_op,
   input  wire [11:0] rel_offset,
   input  wire        const_load,
   input  wire [15:0] prog_word,
   // register read ports
   output reg  [7:0]  src_data,
   output reg  [7:0]  dst_data,
   output reg  [7:0]  imm_data,
   // data bus toward i/o and sram
   output reg  [15:0] data_addr,
   output reg         data_sel_io,
   output reg         data_sel_sram,
   output reg         data_sel_none,
   output reg  [6:0]  data_offset,
   output reg         data_we,
   output reg  [7:0]  data_wdata,
   // program side
   output reg  [9:0]  pc_q,
   output reg  [9:0]  const_word_addr,
   output reg         const_high_byte,
   output reg  [7:0]  const_byte
);

   // ==================================================
   // storage
   reg  [7:0]  regs_q [0:31];
   reg  [15:0] eff_addr;
   reg  [15:0] ptr_val;
   reg  [15:0] ptr_new;
   reg         ptr_we;
   reg  [4:0]  ptr_lo_idx;
   reg         mem_active;
   wire        dec_reg;
   wire        dec_io;
   wire        dec_sram;
   wire        dec_none;
   wire [6:0]  dec_off;
   integer     i;

   // pointer pair read: low byte index even, high byte next
   function [15:0] pair_read;
      input [4:0] lo;
      begin
         pair_read = {regs_q[lo + 5'h01], regs_q[lo]};
      end
   endfunction

   // pointer select to low-byte index
   function [4:0] ptr_index;
      input [1:0] sel;
      begin
         case (sel)
            2'h1:    ptr_index = `PTR_B_LO;
            2'h2:    ptr_index = `PTR_C_LO;
            default: ptr_index = `PTR_A_LO;
         endcase
      end
   endfunction

   // ==================================================
   // effective address generation
   always @* begin
      ptr_lo_idx = ptr_index(ptr_sel);
      ptr_val    = pair_read(ptr_lo_idx);
      ptr_new    = ptr_val;
      ptr_we     = 1'b0;
      mem_active = 1'b1;
      eff_addr   = 16'h0000;
      case (addr_mode)
         `AM_DIRECT: begin
            eff_addr = direct_word;
         end
         `AM_IO: begin
            eff_addr = {8'h00, 2'b00, io_field} + 16'h0020;
         end
         `AM_INDIRECT: begin
            eff_addr = ptr_val;
         end
         `AM_DISP: begin
            // select 0 (pointer a) falls back to b; select 3 still adds to pointer a
            if (ptr_sel == 2'h0)
               ptr_val = pair_read(`PTR_B_LO);
            eff_addr = ptr_val + {10'h000, disp_field};
         end
         `AM_PREDEC: begin
            ptr_new  = ptr_val - 16'h0001;
            ptr_we   = 1'b1;
            eff_addr = ptr_new;
         end
         `AM_POSTINC: begin
            ptr_new  = ptr_val + 16'h0001;
            ptr_we   = 1'b1;
            eff_addr = ptr_val;
         end
         default: begin
            mem_active = 1'b0;
         end
      endcase
   end

   data_space_decode u_decode (
      .addr     (eff_addr),
      .sel_reg  (dec_reg),
      .sel_io   (dec_io),
      .sel_sram (dec_sram),
      .sel_none (dec_none),
      .offset   (dec_off)
   );

   // ==================================================
   // register file write
   // priority: alu, then immediate, then memory load or store into register, then
   // pointer write-back last so a pointer step is never half lost
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < 32; i = i + 1)
            regs_q[i] <= `REG_RESET;
      end else begin
         if (alu_we)
            regs_q[destination_operand_reg] <= alu_result;   // same-cycle writeback
         if (imm_we)
            regs_q[{1'b1, imm_reg}] <= imm_result;           // upper half only
         if (mem_active && !mem_write) begin
            if (dec_reg)
               regs_q[xfer_reg] <= regs_q[dec_off[4:0]];     // register as data location
            else
               regs_q[xfer_reg] <= mem_rdata;
         end
         if (mem_active && mem_write && dec_reg)
            regs_q[dec_off[4:0]] <= regs_q[xfer_reg];
         if (ptr_we) begin
            regs_q[ptr_lo_idx]          <= ptr_new[7:0];     // both bytes together
            regs_q[ptr_lo_idx + 5'h01]  <= ptr_new[15:8];
         end
      end
   end

   // ==================================================
   // registered read ports and data bus
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         src_data      <= 8'h00;
         dst_data      <= 8'h00;
         imm_data      <= 8'h00;
         data_addr     <= 16'h0000;
         data_sel_io   <= 1'b0;
         data_sel_sram <= 1'b0;
         data_sel_none <= 1'b0;
         data_offset   <= 7'h00;
         data_we       <= 1'b0;
         data_wdata    <= 8'h00;
      end else begin
         src_data      <= regs_q[source_operand_reg];
         dst_data      <= regs_q[destination_operand_reg];
         imm_data      <= regs_q[{1'b1, imm_reg}];
         data_addr     <= eff_addr;
         data_sel_io   <= mem_active & dec_io;
         data_sel_sram <= mem_active & dec_sram;
         data_sel_none <= mem_active & dec_none;
         data_offset   <= dec_off;
         // register-space stores stay inside; refused addresses never strobe
         data_we       <= mem_active & mem_write & ~dec_reg & ~dec_none;
         data_wdata    <= regs_q[xfer_reg];
      end
   end

   // ==================================================
   // program counter and constant lookup
   // relative sum kept to ten bits so it folds within 1024 words
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pc_q            <= `PC_RESET;
         const_word_addr <= 10'h000;
         const_high_byte <= 1'b0;
         const_byte      <= 8'h00;
      end else begin
         case (pc_op)
            `PC_STEP:     pc_q <= pc_q + 10'h001;
            `PC_POINTER:  pc_q <= regs_q[`PTR_C_LO + 5'h01] == 8'h00 ?
                                  {2'b00, regs_q[`PTR_C_LO]} :
                                  {regs_q[`PTR_C_LO + 5'h01][1:0], regs_q[`PTR_C_LO]};
            `PC_RELATIVE: pc_q <= pc_q + rel_offset[9:0] + 10'h001;
            default:      pc_q <= pc_q;
         endcase
         if (const_load) begin
            // word select from upper 15 bits, byte from bit zero
            // only ten word bits exist, so pointer bits 10..1 are kept on purpose
            const_word_addr <= {regs_q[`PTR_C_LO + 5'h01][2:0], regs_q[`PTR_C_LO][7:1]};
            const_high_byte <= regs_q[`PTR_C_LO][0];
         end
         const_byte <= const_high_byte ? prog_word[15:8] : prog_word[7:0];
      end
   end

endmodule

//--- hdl/data_space_decode.v
// data space decoder: splits an address into register, i/o and sram selects
// assumes a purely combinational use by the register file top
`timescale 1ns/1ps
`include "regfile_consts.vh"

module data_space_decode (
   // address in
   input  wire [15:0] addr,
   // selects out
   output reg         sel_reg,
   output reg         sel_io,
   output reg         sel_sram,
   output reg         sel_none,
   output reg  [6:0]  offset
);

   // ==================================================
   // region decode
   // only the low byte is decoded once the high byte is proven zero
   always @* begin
      sel_reg  = 1'b0;
      sel_io   = 1'b0;
      sel_sram = 1'b0;
      sel_none = 1'b0;
      offset   = 7'h00;
      if (addr[15:8] != 8'h00) begin
         sel_none = 1'b1;                                    // beyond 224 locations
      end else if (addr[7:0] <= `REG_LAST) begin
         sel_reg = 1'b1;
         offset  = {2'b00, addr[4:0]};
      end else if (addr[7:0] <= `IO_LAST) begin
         sel_io = 1'b1;                                      // i/o zero at 0x20
         offset = {1'b0, addr[5:0] - 6'h20};
      end else if (addr[7:0] <= `SRAM_LAST) begin
         sel_sram = 1'b1;
         offset   = addr[6:0] - 7'h60;
      end else begin
         sel_none = 1'b1;
      end
   end

endmodule

//--- hdl/regfile_consts.vh
// constants for the working register file and address generator
// assumes inclusion by bare name from the design files under hdl/
// Notes on behaviour
// - working registers also appear as data addresses 0x00 to 0x1f.
// - every register reachable directly, single cycle, except immediate group.
// - immediate instructions select only registers 16 to 31.
// - registers 26/27, 28/29, 30/31 form pointers a, b, c (low, high).
// - register operation reads operands and writes result in one cycle.
// - program counter ten bits wide, 1024 sixteen-bit words.
// - data space decodes 224 locations: 96 registers plus i/o, 128 sram.
// - sixty-four i/o registers sit at data addresses 0x20 to 0x5f.
// - direct addressing uses sixteen-bit address from second instruction word.
// - displacement adds 6-bit unsigned field to pointer b or c; design adds it to pointer a when ptr_sel is 3.
// - plain indirect uses pointer contents unchanged as address.
// - pre-decrement lowers pointer, writes it back, uses lowered value.
// - post-increment uses old pointer value, then raises pointer by one.
// - i/o direct takes 6-bit i/o location from instruction field.
// - two-register operations write result into destination register.
// - constant load uses pointer c: upper 15 bits word, bit 0 byte; design keeps only pointer bits 10..1 as word.
// - pointer jump and call load program counter from pointer c.
// - relative jump and call set pc to pc plus offset plus one.
`ifndef REGFILE_CONSTS_VH
`define REGFILE_CONSTS_VH

// ==================================================
// data space map
`define REG_LAST      8'h1f
`define IO_FIRST      8'h20
`define IO_LAST       8'h5f
`define SRAM_FIRST    8'h60
`define SRAM_LAST     8'hdf
`define IMM_REG_BASE  5'h10

// ==================================================
// pointer register indices
`define PTR_A_LO      5'h1a
`define PTR_B_LO      5'h1c
`define PTR_C_LO      5'h1e

// ==================================================
// addressing modes
`define AM_NONE       3'h0
`define AM_DIRECT     3'h1
`define AM_IO         3'h2
`define AM_INDIRECT   3'h3
`define AM_DISP       3'h4
`define AM_PREDEC     3'h5
`define AM_POSTINC    3'h6

// ==================================================
// program counter operations
`define PC_STEP       2'h0
`define PC_POINTER    2'h1
`define PC_RELATIVE   2'h2
`define PC_HOLD       2'h3

// ==================================================
// reset values
`define PC_RESET      10'h000
`define REG_RESET     8'h00

`endif

//--- verif/regfile_checker.sv
// checker: port relations of the register file and address generator
// assumes a bind from the testbench top; one clock domain
`timescale 1ns/1ps
`include "regfile_consts.vh"
module regfile_checker (
   // clock and reset
   input wire        sys_clk,
   input wire        resetn,
   // requests
   input wire [2:0]  addr_mode,
   input wire [15:0] direct_word,
   input wire [5:0]  io_field,
   input wire [1:0]  pc_op,
   input wire [11:0] rel_offset,
   input wire        const_load,
   input wire [15:0] prog_word,
   // answers
   input wire [15:0] data_addr,
   input wire        data_sel_io,
   input wire        data_sel_sram,
   input wire        data_sel_none,
   input wire        data_we,
   input wire [9:0]  pc_q,
   input wire        const_high_byte,
   input wire [7:0]  const_byte
);
   // ==========================================
   // helpers
   // targets are formed here so each property compares against one value
   wire [9:0]  pc_next  = pc_q + 10'h001;
   wire [9:0]  rel_next = pc_q + rel_offset[9:0] + 10'h001;
   wire [15:0] io_addr  = {10'h000, io_field} + 16'h0020;
   wire [7:0]  pick     = const_high_byte ? prog_word[15:8] : prog_word[7:0];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_access;
      $past(addr_mode) != `AM_NONE;
   endsequence
   sequence s_rel;
      pc_op == `PC_RELATIVE;
   endsequence
   // ==========================================
   // assertions
   a_io_direct: assert property ($past(addr_mode) == `AM_IO |-> data_addr == $past(io_addr))
      else $error("i/o direct address wrong");
   a_direct_addr: assert property ($past(addr_mode) == `AM_DIRECT |-> data_addr == $past(direct_word))
      else $error("direct address wrong");
   a_sel_io: assert property (s_access ##0 (data_addr >= 16'h0020 && data_addr <= 16'h005f) |-> data_sel_io)
      else $error("i/o select missing");
   a_sel_sram: assert property (s_access ##0 (data_addr >= 16'h0060 && data_addr <= 16'h00df) |-> data_sel_sram)
      else $error("sram select missing");
   a_sel_none: assert property (s_access ##0 data_addr > 16'h00df |-> data_sel_none && !data_we)
      else $error("out of range not refused");
   a_store_low: assert property (data_we |-> data_addr >= 16'h0020 && data_addr <= 16'h00df)
      else $error("store outside i/o and sram");
   a_pc_step: assert property (pc_op == `PC_STEP |=> pc_q == $past(pc_next))
      else $error("pc step wrong");
   a_pc_rel: assert property (s_rel |=> pc_q == $past(rel_next))
      else $error("relative pc wrong");
   a_const_pick: assert property ($past(const_load) && $past(resetn) |-> const_byte == $past(pick))
      else $error("constant byte wrong");
endmodule

//--- verif/testbench.sv
// self-checking bench for the register file and address generator
// assumes design and checker compiled first, include path reaching hdl/
`timescale 1ns/1ps
`include "regfile_consts.vh"
module testbench;
   logic        sys_clk = 1'b0, resetn = 1'b0, alu_we = 1'b0, imm_we = 1'b0, mem_write = 1'b0, const_load = 1'b0;
   logic [4:0]  destination_operand_reg = 5'h00, source_operand_reg = 5'h00, xfer_reg = 5'h05;
   logic [7:0]  alu_result = 8'h00, imm_result = 8'h00, mem_rdata = 8'h5a;
   logic [3:0]  imm_reg = 4'h0;
   logic [2:0]  addr_mode = 3'h0;
   logic [1:0]  ptr_sel = 2'h0, pc_op = 2'h3;
   logic [5:0]  disp_field = 6'h00, io_field = 6'h00;
   logic [15:0] direct_word = 16'h0000, prog_word = 16'h0000;
   logic [11:0] rel_offset = 12'h000;
   wire  [7:0]  src_data, dst_data, imm_data, data_wdata, const_byte;
   wire  [15:0] data_addr;
   wire         data_sel_io, data_sel_sram, data_sel_none, data_we, const_high_byte;
   wire  [6:0]  data_offset;
   wire  [9:0]  pc_q, const_word_addr;
   int          miscompares = 0, total_checks = 0;
   cpu_regfile_address_gen u_cpu_regfile_address_gen (.*);
   initial forever #10 sys_clk = ~sys_clk;
   // ==========================================
   // shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [4:0] r, input logic [7:0] v);
      @(posedge sys_clk);
      alu_we <= 1'b1;
      destination_operand_reg <= r;
      alu_result <= v;
      @(posedge sys_clk);
      alu_we <= 1'b0;
   endtask
   // two edges allow for the registered read port
   task automatic rd(input logic [4:0] r, input logic [7:0] e);
      @(posedge sys_clk);
      source_operand_reg <= r;
      destination_operand_reg <= r;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(src_data, e);
      chk(dst_data, e);
   endtask
   // dw also feeds the 6-bit i/o and displacement fields
   task automatic acc(input logic [2:0] m, input logic [1:0] p, input logic [15:0] dw, input logic w,
                      input logic [15:0] e);
      @(posedge sys_clk);
      addr_mode <= m;
      ptr_sel <= p;
      direct_word <= dw;
      io_field <= dw[5:0];
      disp_field <= dw[5:0];
      mem_write <= w;
      @(posedge sys_clk);
      addr_mode <= `AM_NONE;
      mem_write <= 1'b0;
      @(negedge sys_clk);
      chk(data_addr, e);
   endtask
   task automatic pcs(input logic [1:0] op, input logic [11:0] k, input logic [9:0] e);
      @(posedge sys_clk);
      pc_op <= op;
      rel_offset <= k;
      @(posedge sys_clk);
      pc_op <= `PC_HOLD;
      @(negedge sys_clk);
      chk(pc_q, e);
   endtask
   // ==========================================
   // scenarios
   task automatic t_regs;
      for (int i = 0; i < 32; i++) wr(i[4:0], 8'h80 + i[7:0]);
      for (int i = 0; i < 32; i++) rd(i[4:0], 8'h80 + i[7:0]);
      @(posedge sys_clk);
      imm_we <= 1'b1;
      imm_reg <= 4'hf;
      imm_result <= 8'h3c;
      @(posedge sys_clk);
      imm_we <= 1'b0;
      rd(5'h1f, 8'h3c);
      chk(imm_data, 8'h3c);
      rd(5'h0f, 8'h8f);
   endtask
   // pointers a=0x0060, b=0x0100, c=0x00ff exercise both carry directions
   task automatic t_ptr;
      wr(5'h1a, 8'h60);
      wr(5'h1b, 8'h00);
      wr(5'h1c, 8'h00);
      wr(5'h1d, 8'h01);
      wr(5'h1e, 8'hff);
      wr(5'h1f, 8'h00);
      acc(`AM_INDIRECT, 2'h1, 16'h0000, 1'b0, 16'h0100);
      acc(`AM_DISP, 2'h1, 16'h003f, 1'b0, 16'h013f);
      acc(`AM_POSTINC, 2'h0, 16'h0000, 1'b0, 16'h0060);
      rd(5'h1a, 8'h61);
      rd(5'h05, 8'h5a);
      acc(`AM_PREDEC, 2'h1, 16'h0000, 1'b0, 16'h00ff);
      rd(5'h1c, 8'hff);
      rd(5'h1d, 8'h00);
      acc(`AM_POSTINC, 2'h2, 16'h0000, 1'b0, 16'h00ff);
      rd(5'h1e, 8'h00);
      rd(5'h1f, 8'h01);
   endtask
   task automatic t_map;
      logic [15:0] tbl [5] = '{16'h0020, 16'h005f, 16'h0060, 16'h00df, 16'h00e0};
      logic [6:0]  offs [5] = '{7'h00, 7'h3f, 7'h00, 7'h7f, 7'h00};
      wr(5'h1a, 8'h03);
      wr(5'h1b, 8'h00);
      acc(`AM_INDIRECT, 2'h0, 16'h0000, 1'b0, 16'h0003);
      rd(5'h05, 8'h83);
      acc(`AM_IO, 2'h0, 16'h0000, 1'b0, 16'h0020);
      acc(`AM_IO, 2'h0, 16'h003f, 1'b0, 16'h005f);
      for (int i = 0; i < 5; i++) begin
         acc(`AM_DIRECT, 2'h0, tbl[i], 1'b1, tbl[i]);
         chk({data_sel_io, data_sel_sram, data_sel_none}, (i < 2) ? 3'h4 : (i < 4) ? 3'h2 : 3'h1);
         chk(data_we, i < 4);
         chk(data_offset, offs[i]);
         chk(data_wdata, 8'h5a);
      end
      // a store into register space lands internally with no bus strobe
      acc(`AM_DIRECT, 2'h0, 16'h0007, 1'b1, 16'h0007);
      chk(data_we, 1'b0);
      rd(5'h07, 8'h5a);
   endtask
   // a reset in mid-run must clear the pointer c high byte and pc at once
   task automatic t_rst;
      @(posedge sys_clk);
      const_load <= 1'b0;
      resetn <= 1'b0;
      @(posedge sys_clk);
      resetn <= 1'b1;
      @(negedge sys_clk);
      chk(pc_q, `PC_RESET);
      rd(5'h1f, `REG_RESET);
   endtask
   task automatic t_pc;
      pcs(`PC_RELATIVE, 12'h3fe, 10'h3ff);
      pcs(`PC_STEP, 12'h000, 10'h000);
      pcs(`PC_RELATIVE, 12'h800, 10'h001);
      pcs(`PC_RELATIVE, 12'h7ff, 10'h001);
      pcs(`PC_POINTER, 12'h000, 10'h100);
      wr(5'h1e, 8'h03);
      wr(5'h1f, 8'h02);
      @(posedge sys_clk);
      const_load <= 1'b1;
      prog_word <= 16'hbeef;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(const_word_addr, 10'h101);
      chk(const_byte, 8'hbe);
      wr(5'h1e, 8'h02);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(const_byte, 8'hef);
   endtask
   // ==========================================
   // main sequence and watchdog
   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      @(negedge sys_clk);
      chk(pc_q, 10'h000);
      t_regs;
      t_ptr;
      t_map;
      t_pc;
      t_rst;
      test_done;
   end
   // the run needs a few hundred cycles; this limit leaves ample margin
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      test_done;
   end
endmodule
bind cpu_regfile_address_gen regfile_checker u_regfile_checker (.*);
